// ==== verilog/bwd_consts.vh ====
`ifndef BWD_CONSTS_VH
`define BWD_CONSTS_VH

// APB address width and register indexes (byte address = index * 4)
`define BWD_PADDR_W        10
`define BWD_IDX_CMD        8'h04
`define BWD_IDX_IO_BASE    8'h1c
`define BWD_IDX_IO_LIMIT   8'h1d
`define BWD_IDX_MEM_BASE   8'h20
`define BWD_IDX_MEM_LIMIT  8'h22
`define BWD_IDX_PF_BASE    8'h24
`define BWD_IDX_PF_LIMIT   8'h26
`define BWD_IDX_PF_BASE_UP 8'h28
`define BWD_IDX_PF_LIM_UP  8'h2c
`define BWD_IDX_IO_BASE_UP 8'h30
`define BWD_IDX_IO_LIM_UP  8'h32
`define BWD_IDX_BRG_CFG    8'h40

// Command register fields
`define BWD_CMD_IO_EN      0
`define BWD_CMD_MEM_EN     1
`define BWD_CMD_BM_EN      2
`define BWD_CMD_RESET      16'h0000

// Bridge configuration field
`define BWD_CFG_FINE_IO    0

// Hardwired low nibbles of the window registers
`define BWD_MEM_LOW_NIB    4'h0
`define BWD_PF_LOW_NIB     4'h1

// Implied low address bits of expanded windows
`define BWD_IO4K_BASE_LO   12'h000
`define BWD_IO4K_LIM_LO    12'hfff
`define BWD_IO1K_BASE_LO   10'h000
`define BWD_IO1K_LIM_LO    10'h3ff
`define BWD_MEM_BASE_LO    20'h00000
`define BWD_MEM_LIM_LO     20'hfffff

`endif

// ==== verilog/bwd_range_cmp.v ====
`timescale 1ns/1ns
// Inclusive window compare; a base above the limit disables the window
module bwd_range_cmp #(
  parameter WIDTH = 32
) (
  input  wire [WIDTH-1:0] base,
  input  wire [WIDTH-1:0] limit,
  input  wire [WIDTH-1:0] addr,
  output wire             hit
);

  // Window on and address between both ends
  assign hit = (base <= limit) && (base <= addr) && (addr <= limit);

endmodule

// ==== verilog/bwd_decode.v ====
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
`include "bwd_consts.vh"
// Function
// - I/O disabled in command register: all upstream I/O gets master abort.
// - Downstream-originated I/O never crosses upstream; always master aborted.
// - Upstream I/O inside the I/O window is forwarded downstream.
// - Downstream I/O outside the I/O window is master aborted.
// - I/O base above limit turns the I/O window off.
// - I/O base byte: upper nibble is address 15:12, low nibble reads zero.
// - I/O limit byte: upper nibble is address 15:12, low bits implied ones.
// - Upper 16-bit I/O base and limit registers are reserved.
// - After reset effective I/O base is 0000h, limit 0FFFh.
// - Fine granularity: upper six bits give address 15:10, low two read zero.
// - Upstream memory forwarded only while memory space enable is set.
// - Downstream memory forwarded only while bus master enable is set.
// - No speculative prefetch; only the requested length is read.
// - 64-bit dual-address cycles accepted and generated on both sides.
// - Non-prefetchable hits go downstream; misses go upstream unless prefetch hit.
// - Memory base/limit: upper 12 bits are address 31:20, low nibble zero.
// - Memory base above limit disables the non-prefetchable window.
// - Prefetch hits go downstream; upstream only when missing both windows.
// - Prefetch base/limit: upper 12 bits are 31:20, low nibble reads 1h.
// - Prefetch upper 32 bits join the low part as one 64-bit range.
// - Full 64-bit prefetch base above limit disables the window.
module bwd_decode #(
  parameter LEN_W = 8
) (
  input  wire                    CLK,
  input  wire                    RST,
  // APB slave
  input  wire                    PSEL,
  input  wire                    PENABLE,
  input  wire                    PWRITE,
  input  wire [`BWD_PADDR_W-1:0] PADDR,
  input  wire [31:0]             PWDATA,
  output reg  [31:0]             PRDATA,
  output wire                    PREADY,
  output wire                    PSLVERR,
  // Transaction to decode
  input  wire                    TXN_VALID,
  input  wire                    TXN_INBOUND,
  input  wire                    TXN_IS_IO,
  input  wire [63:0]             TXN_ADDR,
  input  wire [LEN_W-1:0]        TXN_LEN,
  // Decode result
  output reg                     DEC_VALID,
  output reg                     DEC_FORWARD,
  output reg                     DEC_ABORT,
  output reg                     DEC_DAC,
  output reg  [LEN_W-1:0]        DEC_LEN
);

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg  [15:0] command_reg;
  reg         fine_io_granularity_enable_reg;
  reg  [5:0]  io_window_base_reg;
  reg  [5:0]  io_window_limit_reg;
  reg  [11:0] memory_window_base_reg;
  reg  [11:0] memory_window_limit_reg;
  reg  [11:0] prefetch_window_base_reg;
  reg  [11:0] prefetch_window_limit_reg;
  reg  [31:0] prefetch_base_upper_reg;
  reg  [31:0] prefetch_limit_upper_reg;

  wire [7:0]  word_idx;
  wire        addr_aligned;
  wire        wr_en;
  wire        setup;
  reg         mapped;
  reg  [31:0] rd_value;
  reg  [7:0]  io_base_view;
  reg  [7:0]  io_limit_view;

  assign word_idx     = PADDR[9:2];
  assign addr_aligned = (PADDR[1:0] == 2'b00);
  assign setup        = PSEL && !PENABLE;
  assign wr_en        = PSEL && PENABLE && PWRITE && mapped;

  // Zero wait states; unmapped word answers with an error
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  // I/O bytes read back with the low bits zero for the active granularity
  always @* begin
    if (fine_io_granularity_enable_reg) begin
      io_base_view  = {io_window_base_reg, 2'b00};
      io_limit_view = {io_window_limit_reg, 2'b00};
    end else begin
      io_base_view  = {io_window_base_reg[5:2], 4'h0};
      io_limit_view = {io_window_limit_reg[5:2], 4'h0};
    end
  end

  // Address decode and read mux
  always @* begin
    mapped   = addr_aligned;
    rd_value = 32'h0000_0000;
    case (word_idx)
      `BWD_IDX_CMD:        rd_value = {16'h0000, command_reg};
      `BWD_IDX_IO_BASE:    rd_value = {24'h000000, io_base_view};
      `BWD_IDX_IO_LIMIT:   rd_value = {24'h000000, io_limit_view};
      `BWD_IDX_MEM_BASE:
        rd_value = {16'h0000, memory_window_base_reg, `BWD_MEM_LOW_NIB};
      `BWD_IDX_MEM_LIMIT:
        rd_value = {16'h0000, memory_window_limit_reg, `BWD_MEM_LOW_NIB};
      `BWD_IDX_PF_BASE:
        rd_value = {16'h0000, prefetch_window_base_reg, `BWD_PF_LOW_NIB};
      `BWD_IDX_PF_LIMIT:
        rd_value = {16'h0000, prefetch_window_limit_reg, `BWD_PF_LOW_NIB};
      `BWD_IDX_PF_BASE_UP: rd_value = prefetch_base_upper_reg;
      `BWD_IDX_PF_LIM_UP:  rd_value = prefetch_limit_upper_reg;
      `BWD_IDX_IO_BASE_UP: rd_value = 32'h0000_0000;
      `BWD_IDX_IO_LIM_UP:  rd_value = 32'h0000_0000;
      `BWD_IDX_BRG_CFG:
        rd_value = {31'h0000_0000, fine_io_granularity_enable_reg};
      default:             mapped   = 1'b0;
    endcase
  end

  // Read data captured in setup so it stands through the access phase
  always @(posedge CLK) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
    end else if (setup && !PWRITE) begin
      PRDATA <= rd_value;
    end
  end

  // Register writes take effect on the access edge
  always @(posedge CLK) begin
    if (RST) begin
      command_reg                    <= `BWD_CMD_RESET;
      fine_io_granularity_enable_reg <= 1'b0;
      io_window_base_reg             <= 6'h00;
      io_window_limit_reg            <= 6'h00;
      memory_window_base_reg         <= 12'h000;
      memory_window_limit_reg        <= 12'h000;
      prefetch_window_base_reg       <= 12'h000;
      prefetch_window_limit_reg      <= 12'h000;
      prefetch_base_upper_reg        <= 32'h0000_0000;
      prefetch_limit_upper_reg       <= 32'h0000_0000;
    end else if (wr_en) begin
      case (word_idx)
        `BWD_IDX_CMD:        command_reg <= PWDATA[15:0];
        // Low two bits cleared in coarse mode, so a later switch to fine mode sees them zero
        `BWD_IDX_IO_BASE: begin
          if (fine_io_granularity_enable_reg) begin
            io_window_base_reg <= PWDATA[7:2];
          end else begin
            io_window_base_reg <= {PWDATA[7:4], 2'b00};
          end
        end
        `BWD_IDX_IO_LIMIT: begin
          if (fine_io_granularity_enable_reg) begin
            io_window_limit_reg <= PWDATA[7:2];
          end else begin
            io_window_limit_reg <= {PWDATA[7:4], 2'b00};
          end
        end
        `BWD_IDX_MEM_BASE:   memory_window_base_reg    <= PWDATA[15:4];
        `BWD_IDX_MEM_LIMIT:  memory_window_limit_reg   <= PWDATA[15:4];
        `BWD_IDX_PF_BASE:    prefetch_window_base_reg  <= PWDATA[15:4];
        `BWD_IDX_PF_LIMIT:   prefetch_window_limit_reg <= PWDATA[15:4];
        `BWD_IDX_PF_BASE_UP: prefetch_base_upper_reg   <= PWDATA;
        `BWD_IDX_PF_LIM_UP:  prefetch_limit_upper_reg  <= PWDATA;
        `BWD_IDX_BRG_CFG:
          fine_io_granularity_enable_reg <= PWDATA[`BWD_CFG_FINE_IO];
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Expanded windows

  reg  [15:0] io_base_full;
  reg  [15:0] io_limit_full;
  wire [31:0] mem_base_full;
  wire [31:0] mem_limit_full;
  wire [63:0] pf_base_full;
  wire [63:0] pf_limit_full;

  // Implied low bits depend on granularity
  always @* begin
    if (fine_io_granularity_enable_reg) begin
      io_base_full  = {io_window_base_reg, `BWD_IO1K_BASE_LO};
      io_limit_full = {io_window_limit_reg, `BWD_IO1K_LIM_LO};
    end else begin
      io_base_full  = {io_window_base_reg[5:2], `BWD_IO4K_BASE_LO};
      io_limit_full = {io_window_limit_reg[5:2], `BWD_IO4K_LIM_LO};
    end
  end

  assign mem_base_full  = {memory_window_base_reg, `BWD_MEM_BASE_LO};
  assign mem_limit_full = {memory_window_limit_reg, `BWD_MEM_LIM_LO};
  // Upper and lower halves form one 64-bit range
  assign pf_base_full   = {prefetch_base_upper_reg,
                           prefetch_window_base_reg, `BWD_MEM_BASE_LO};
  assign pf_limit_full  = {prefetch_limit_upper_reg,
                           prefetch_window_limit_reg, `BWD_MEM_LIM_LO};

  ////////////////////////////////////////////////////////////////////////////
  // Window compares

  wire io_hit_lo;
  wire np_hit_lo;
  wire pf_hit;
  wire io_hit;
  wire np_hit;

  // I/O window, 16-bit space only
  bwd_range_cmp #(.WIDTH(16)) u_io_cmp (
    .base  (io_base_full),
    .limit (io_limit_full),
    .addr  (TXN_ADDR[15:0]),
    .hit   (io_hit_lo)
  );

  // Non-prefetchable window, 32-bit space only
  bwd_range_cmp #(.WIDTH(32)) u_np_cmp (
    .base  (mem_base_full),
    .limit (mem_limit_full),
    .addr  (TXN_ADDR[31:0]),
    .hit   (np_hit_lo)
  );

  // Prefetchable window over full 64 bits
  bwd_range_cmp #(.WIDTH(64)) u_pf_cmp (
    .base  (pf_base_full),
    .limit (pf_limit_full),
    .addr  (TXN_ADDR),
    .hit   (pf_hit)
  );

  // Addresses above the window's space can never hit it
  assign io_hit = io_hit_lo && (TXN_ADDR[63:16] == 48'h0);
  assign np_hit = np_hit_lo && (TXN_ADDR[63:32] == 32'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Forwarding decision

  wire io_en;
  wire mem_en;
  wire bm_en;
  reg  fwd_next;

  assign io_en  = command_reg[`BWD_CMD_IO_EN];
  assign mem_en = command_reg[`BWD_CMD_MEM_EN];
  assign bm_en  = command_reg[`BWD_CMD_BM_EN];

  // Anything not forwarded is master aborted
  always @* begin
    if (TXN_IS_IO) begin
      if (TXN_INBOUND) begin
        fwd_next = 1'b0;
      end else begin
        fwd_next = io_en && io_hit;
      end
    end else if (TXN_INBOUND) begin
      fwd_next = bm_en && !np_hit && !pf_hit;
    end else begin
      fwd_next = mem_en && (np_hit || pf_hit);
    end
  end

  // One-cycle registered result; length passed unchanged, never extended
  always @(posedge CLK) begin
    if (RST) begin
      DEC_VALID   <= 1'b0;
      DEC_FORWARD <= 1'b0;
      DEC_ABORT   <= 1'b0;
      DEC_DAC     <= 1'b0;
      DEC_LEN     <= {LEN_W{1'b0}};
    end else begin
      DEC_VALID   <= TXN_VALID;
      DEC_FORWARD <= TXN_VALID && fwd_next;
      DEC_ABORT   <= TXN_VALID && !fwd_next;
      DEC_DAC     <= TXN_VALID && fwd_next && !TXN_IS_IO
                     && (TXN_ADDR[63:32] != 32'h0);
      DEC_LEN     <= TXN_LEN;
    end
  end

endmodule

// ==== verif/bwd_decode_properties.sv ====
`timescale 1ns/1ns
// Port-level checks of the window decoder
module bwd_decode_props #(
  parameter LEN_W = 8
) (
  input wire             CLK,
  input wire             RST,
  input wire             PSEL,
  input wire             PENABLE,
  input wire             PSLVERR,
  input wire             TXN_VALID,
  input wire             TXN_INBOUND,
  input wire             TXN_IS_IO,
  input wire [63:0]      TXN_ADDR,
  input wire [LEN_W-1:0] TXN_LEN,
  input wire             DEC_VALID,
  input wire             DEC_FORWARD,
  input wire             DEC_ABORT,
  input wire             DEC_DAC,
  input wire [LEN_W-1:0] DEC_LEN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  ////////////////////////////////////////////////////////////
  chk_result_pulse: assert property (DEC_VALID == $past(TXN_VALID))
    else $error("decode result not one cycle after request");
  chk_one_result: assert property (DEC_VALID |-> DEC_FORWARD ^ DEC_ABORT)
    else $error("result not exactly one of forward and abort");
  chk_no_stray: assert property (!DEC_VALID |-> !(DEC_FORWARD || DEC_ABORT))
    else $error("result flag without valid");
  chk_inbound_io: assert property (TXN_VALID && TXN_INBOUND && TXN_IS_IO |=> DEC_ABORT)
    else $error("inbound io not aborted");
  chk_io_high_addr: assert property (TXN_VALID && TXN_IS_IO && (TXN_ADDR[63:16] != 48'h0) |=> DEC_ABORT)
    else $error("io above 64K not aborted");
  chk_len_copy: assert property (TXN_VALID |=> DEC_LEN == $past(TXN_LEN))
    else $error("length not passed unchanged");
  chk_dac_low: assert property (TXN_VALID && (TXN_IS_IO || TXN_ADDR[63:32] == 32'h0) |=> !DEC_DAC)
    else $error("dual address flagged for low address");
  chk_err_phase: assert property (!(PSEL && PENABLE) |-> !PSLVERR)
    else $error("slave error outside access phase");
  // Main scenarios reached
  cover property (TXN_VALID ##1 DEC_FORWARD);
  cover property (DEC_DAC);
  cover property (PSEL && PENABLE && PSLVERR);
endmodule

bind bwd_decode bwd_decode_props #(.LEN_W(LEN_W)) u_props (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PSLVERR(PSLVERR),
  .TXN_VALID(TXN_VALID), .TXN_INBOUND(TXN_INBOUND), .TXN_IS_IO(TXN_IS_IO),
  .TXN_ADDR(TXN_ADDR), .TXN_LEN(TXN_LEN), .DEC_VALID(DEC_VALID),
  .DEC_FORWARD(DEC_FORWARD), .DEC_ABORT(DEC_ABORT), .DEC_DAC(DEC_DAC),
  .DEC_LEN(DEC_LEN));

// ==== verif/bwd_agent.sv ====
`timescale 1ns/1ns
// Transaction source standing for the hub side and the bus agents
module bwd_agent (
  input  wire        CLK,
  output reg         TXN_VALID,
  output reg         TXN_INBOUND,
  output reg         TXN_IS_IO,
  output reg  [63:0] TXN_ADDR,
  output reg  [7:0]  TXN_LEN
);
  initial begin
    TXN_VALID = 1'b0;
    TXN_INBOUND = 1'b0;
    TXN_IS_IO = 1'b0;
    TXN_ADDR = 64'h0;
    TXN_LEN = 8'h00;
  end
  // One-cycle request; fields flip afterwards so stale values never help
  task send(input logic inb, input logic io, input logic [63:0] a,
            input logic [7:0] len);
    begin
      @(posedge CLK);
      TXN_VALID <= 1'b1;
      TXN_INBOUND <= inb;
      TXN_IS_IO <= io;
      TXN_ADDR <= a;
      TXN_LEN <= len;
      @(posedge CLK);
      TXN_VALID <= 1'b0;
      TXN_INBOUND <= ~inb;
      TXN_IS_IO <= ~io;
      TXN_ADDR <= ~a;
      TXN_LEN <= ~len;
    end
  endtask
endmodule

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`include "bwd_consts.vh"
// Register and decode tests of the window decoder
module tb;
  localparam [9:0] CMD = 10'h010, IOB = 10'h070, IOL = 10'h074;
  localparam [9:0] MB = 10'h080, ML = 10'h088, PB = 10'h090, PL = 10'h098;
  localparam [9:0] PBU = 10'h0a0, PLU = 10'h0b0, CFG = 10'h100;
  reg                    CLK = 1'b0;
  reg                    RST = 1'b1;
  reg                    PSEL = 1'b0;
  reg                    PENABLE = 1'b0;
  reg                    PWRITE = 1'b0;
  reg [`BWD_PADDR_W-1:0] PADDR = 10'h000;
  reg [31:0]             PWDATA = 32'h0;
  wire [31:0]            PRDATA;
  wire                   PREADY, PSLVERR, TXN_VALID, TXN_INBOUND, TXN_IS_IO;
  wire [63:0]            TXN_ADDR;
  wire [7:0]             TXN_LEN, DEC_LEN;
  wire                   DEC_VALID, DEC_FORWARD, DEC_ABORT, DEC_DAC;
  reg [31:0]             rd_val;
  reg                    rd_err;
  integer                bad_count = 0;
  integer                num_checks = 0;

  always #4 CLK = ~CLK;

  bwd_agent u_agent (.CLK(CLK), .TXN_VALID(TXN_VALID),
    .TXN_INBOUND(TXN_INBOUND), .TXN_IS_IO(TXN_IS_IO), .TXN_ADDR(TXN_ADDR),
    .TXN_LEN(TXN_LEN));
  bwd_decode u_dut (.CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .TXN_VALID(TXN_VALID),
    .TXN_INBOUND(TXN_INBOUND), .TXN_IS_IO(TXN_IS_IO), .TXN_ADDR(TXN_ADDR),
    .TXN_LEN(TXN_LEN), .DEC_VALID(DEC_VALID), .DEC_FORWARD(DEC_FORWARD),
    .DEC_ABORT(DEC_ABORT), .DEC_DAC(DEC_DAC), .DEC_LEN(DEC_LEN));
  ////////////////////////////////////////////////////////////
  task chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  // APB master: request held until pready is seen at an edge
  task apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
    begin
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= wr;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      @(posedge CLK);
      while (PREADY !== 1'b1) @(posedge CLK);
      rd_val = PRDATA;
      rd_err = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  task wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [9:0] a, input logic [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk("read data", rd_val, exp);
      chk("read error", rd_err, 1'b0);
      chk("ready", PREADY, 1'b1);
    end
  endtask
  // Decode one transaction and compare the registered result
  task txn(input logic inb, input logic io, input logic [63:0] a,
           input logic fwd, input logic dac);
    begin
      u_agent.send(inb, io, a, a[7:0]);
      #1;
      chk("valid", DEC_VALID, 1'b1);
      chk("forward", DEC_FORWARD, fwd);
      chk("abort", DEC_ABORT, !fwd);
      chk("dual address", DEC_DAC, dac);
      chk("length", DEC_LEN, a[7:0]);
    end
  endtask
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    #100000;
    bad_count = bad_count + 1;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge CLK);
    RST <= 1'b0;
    rd(CMD, 32'h0);
    rd(IOL, 32'h0);
    rd(PB, 32'h1);
    txn(0, 1, 64'h0, 0, 0);
    wr(CMD, 32'h1);
    txn(0, 1, 64'h0fff, 1, 0);
    txn(0, 1, 64'h1000, 0, 0);
    wr(IOB, 32'hff);
    rd(IOB, 32'hf0);
    wr(IOL, 32'hff);
    rd(IOL, 32'hf0);
    wr(10'h0c0, 32'hffff);
    rd(10'h0c0, 32'h0);
    rd(10'h0c8, 32'h0);
    apb(0, 10'h3fc, 32'h0);
    chk("unmapped error", rd_err, 1'b1);
    $display("test registers done");
    wr(IOB, 32'h20);
    wr(IOL, 32'h30);
    txn(0, 1, 64'h1fff, 0, 0);
    txn(0, 1, 64'h2000, 1, 0);
    txn(0, 1, 64'h3fff, 1, 0);
    txn(0, 1, 64'h4000, 0, 0);
    txn(1, 1, 64'h2000, 0, 0);
    txn(1, 1, 64'h8000, 0, 0);
    wr(CMD, 32'h0);
    txn(0, 1, 64'h2000, 0, 0);
    wr(CMD, 32'h1);
    wr(IOB, 32'h40);
    txn(0, 1, 64'h3000, 0, 0);
    wr(CFG, 32'h1);
    wr(IOB, 32'h27);
    rd(IOB, 32'h24);
    wr(IOL, 32'h27);
    txn(0, 1, 64'h23ff, 0, 0);
    txn(0, 1, 64'h2400, 1, 0);
    txn(0, 1, 64'h27ff, 1, 0);
    txn(0, 1, 64'h2800, 0, 0);
    txn(0, 1, 64'h12400, 0, 0);
    $display("test io window done");
    wr(MB, 32'h123f);
    rd(MB, 32'h1230);
    wr(ML, 32'h1230);
    wr(CMD, 32'h6);
    txn(0, 0, 64'h12300000, 1, 0);
    txn(0, 0, 64'h123fffff, 1, 0);
    txn(0, 0, 64'h12400000, 0, 0);
    txn(1, 0, 64'h12300000, 0, 0);
    txn(1, 0, 64'h50000000, 1, 0);
    wr(CMD, 32'h4);
    txn(0, 0, 64'h12300000, 0, 0);
    wr(CMD, 32'h2);
    txn(1, 0, 64'h50000000, 0, 0);
    wr(CMD, 32'h6);
    wr(MB, 32'h1240);
    txn(0, 0, 64'h12300000, 0, 0);
    wr(PB, 32'h2000);
    rd(PB, 32'h2001);
    wr(PL, 32'h2000);
    wr(PBU, 32'h1);
    wr(PLU, 32'h1);
    rd(PLU, 32'h1);
    txn(0, 0, 64'h120000000, 1, 1);
    txn(0, 0, 64'h1200fffff, 1, 1);
    txn(0, 0, 64'h20000000, 0, 0);
    txn(1, 0, 64'h120000000, 0, 0);
    txn(1, 0, 64'h220000000, 1, 1);
    wr(PBU, 32'h2);
    txn(0, 0, 64'h120000000, 0, 0);
    $display("test memory windows done");
    report_and_stop;
  end
endmodule
